/* core/pll_clk_pkg.sv */
package pll_clk_pkg;

  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;

  // register indices; the byte address on the bus is four times the index
  localparam logic [9:0] CTRL_INDEX   = 10'h03D;
  localparam logic [9:0] DIV_INDEX    = 10'h03E;
  localparam logic [9:0] STATUS_INDEX = 10'h020;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET  = 8'h08;
  localparam logic [7:0] DIV_MIN    = 8'h08;

  // status register bit positions
  localparam int unsigned STAT_PIN_LEVEL  = 0;
  localparam int unsigned STAT_PLL_LEVEL  = 1;
  localparam int unsigned STAT_PIN_DRIVEN = 2;

  // clock source select codes
  localparam logic [3:0] SEL_GPIO  = 4'h0;
  localparam logic [3:0] SEL_PLL   = 4'h1;
  localparam logic [3:0] SEL_LOW   = 4'h2;
  localparam logic [3:0] SEL_HIGH  = 4'h3;
  localparam logic [3:0] SEL_XTAL  = 4'h4;
  localparam logic [3:0] SEL_XTAL2 = 4'h5;
  localparam logic [3:0] SEL_XTAL4 = 4'h6;
  localparam logic [3:0] SEL_XTAL8 = 4'h7;
  // codes 8h..Bh share this upper pair; the low pair picks the timer
  localparam logic [1:0] SEL_TMR_GROUP = 2'h2;

  localparam logic [4:0] FB_MUL_23 = 5'h17;
  localparam logic [4:0] FB_MUL_27 = 5'h1B;
  localparam logic [4:0] FB_MUL_28 = 5'h1C;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ACCESS = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic [3:0] auxClockSourceSelect;
    logic       auxClockPinEnable;
    logic       pllPowerDown;
    logic [1:0] pllFeedbackFactor;
  } pll_ctrl_t;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [APB_DATA_W-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
  } apb_rsp_t;

  function automatic logic [4:0] fb_multiplier(input logic [1:0] code);
    case (code)
      2'b01:   return FB_MUL_27;
      2'b10:   return FB_MUL_28;
      default: return FB_MUL_23;
    endcase
  endfunction

endpackage

/* core/xtal_divider.sv */
`timescale 1ns/10ps
// toggle enables for the divided crystal outputs: pulsing every 2, 4 and 8
// cycles gives pin rates of 1/2, 1/4 and 1/8 of the undivided toggle rate
module xtal_divider (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  output logic [2:0]      toggleEn
);

  typedef struct packed {
    logic [2:0] phase;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  always_comb begin
    next_s       = s;
    next_s.phase = s.phase + 3'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{phase: 3'h0};
    end else begin
      s <= next_s;
    end
  end

  assign toggleEn[0] = s.phase[0];
  assign toggleEn[1] = &s.phase[1:0];
  assign toggleEn[2] = &s.phase;

endmodule

/* core/pll_output_model.sv */
`timescale 1ns/10ps
// digital stand-in for the analog PLL: a phase accumulator advances by the
// feedback factor each crystal cycle and toggles the output whenever it
// passes the output divider, so f_out = f_xtal * fb / 2 / div
module pll_output_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       pllPowerDown,
  input  wire logic [1:0] pllFeedbackFactor,
  input  wire logic [7:0] pllOutputFactor,
  output logic            pllLevel
);

  typedef struct packed {
    logic [8:0] acc;
    logic       level;
  } pll_state_t;

  pll_state_t s;
  pll_state_t next_s;
  logic [8:0] divEff;
  logic [9:0] sum;
  logic [9:0] rest;

  always_comb begin
    next_s = s;
    // reserved factors below the minimum run as the minimum
    divEff = {1'b0, (pllOutputFactor < pll_clk_pkg::DIV_MIN) ? pll_clk_pkg::DIV_MIN
                                                            : pllOutputFactor};
    sum    = {1'b0, s.acc} + {5'h00, pll_clk_pkg::fb_multiplier(pllFeedbackFactor)};
    rest   = sum - {1'b0, divEff};
    if (pllPowerDown) begin
      next_s.acc   = 9'h000;
      next_s.level = 1'b0;
    end else if (sum >= {1'b0, divEff}) begin
      next_s.level = ~s.level;
      // one toggle per cycle at most: faster settings saturate here
      next_s.acc   = (rest >= {1'b0, divEff}) ? divEff - 9'h001 : rest[8:0];
    end else begin
      next_s.acc = sum[8:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{acc: 9'h000, level: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign pllLevel = s.level;

endmodule

/* core/pll_and_clock_output_control.sv */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
// Function
// - code 0h releases pin for general I/O
// - code 1h drives PLL output onto pin
// - code 2h holds pin low, 3h high
// - code 4h passes undivided crystal clock
// - codes 5h-7h give crystal divided 2/4/8
// - codes 8h-Bh toggle pin on timer overflow
// - pin driven only while enable bit set
// - feedback code maps to 23, 27, 28
// - output factor is eight-bit read/write register
// - divide by programmed value 8 to 255
// - multiply, halve, then divide by output factor
module pll_and_clock_output_control (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire pll_clk_pkg::apb_req_t apbReq,
  output pll_clk_pkg::apb_rsp_t     apbRsp,
  input  wire logic [3:0]           timerOverflow,
  input  wire logic                 auxClockPinIn,
  output logic                      auxClockPinOut,
  output logic                      auxClockPinOe
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    pll_clk_pkg::bus_state_t bus;
    pll_clk_pkg::pll_ctrl_t  ctrl;
    logic [7:0]              pllOutputFactor;
    pll_clk_pkg::apb_rsp_t   rsp;
    logic                    pinOut;
    logic                    pinOe;
    logic [2:0]              pinSync;
    logic                    pinLevel;
  } core_state_t;

  localparam core_state_t STATE_RESET = '{
    bus:             pll_clk_pkg::BUS_IDLE,
    ctrl:            pll_clk_pkg::pll_ctrl_t'(pll_clk_pkg::CTRL_RESET),
    pllOutputFactor: pll_clk_pkg::DIV_RESET,
    rsp:             '0,
    pinOut:          1'b0,
    pinOe:           1'b0,
    pinSync:         3'h0,
    pinLevel:        1'b0
  };

  core_state_t s;
  core_state_t next_s;
  logic [2:0]  toggleEn;
  logic        pllLevel;
  logic [2:0]  regHit;
  logic [31:0] rdData;
  logic        accessDone;

  // one-hot {status, divider, control}; zero for an unmapped address
  function automatic logic [2:0] reg_select(input logic [11:0] addr);
    logic [2:0] hit;
    hit    = 3'h0;
    hit[0] = (addr == {pll_clk_pkg::CTRL_INDEX, 2'b00});
    hit[1] = (addr == {pll_clk_pkg::DIV_INDEX, 2'b00});
    hit[2] = (addr == {pll_clk_pkg::STATUS_INDEX, 2'b00});
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  xtal_divider u_xtal_divider (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .toggleEn (toggleEn)
  );

  pll_output_model u_pll_output_model (
    .clk_sys           (clk_sys),
    .rst_n             (rst_n),
    .pllPowerDown      (s.ctrl.pllPowerDown),
    .pllFeedbackFactor (s.ctrl.pllFeedbackFactor),
    .pllOutputFactor   (s.pllOutputFactor),
    .pllLevel          (pllLevel)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s     = s;
    regHit     = reg_select(apbReq.paddr);
    rdData     = 32'h0000_0000;
    accessDone = (s.bus == pll_clk_pkg::BUS_ACCESS) && apbReq.psel && apbReq.penable
                 && s.rsp.pready;

    if (regHit[0]) begin
      rdData[7:0] = s.ctrl;
    end
    if (regHit[1]) begin
      rdData[7:0] = s.pllOutputFactor;
    end
    if (regHit[2]) begin
      rdData[pll_clk_pkg::STAT_PIN_LEVEL]  = s.pinLevel;
      rdData[pll_clk_pkg::STAT_PLL_LEVEL]  = pllLevel;
      rdData[pll_clk_pkg::STAT_PIN_DRIVEN] = s.pinOe;
    end

    // apb slave: read data and error are set up during the setup cycle so
    // the access phase always completes in one cycle
    case (s.bus)
      pll_clk_pkg::BUS_IDLE: begin
        if (apbReq.psel && !apbReq.penable) begin
          next_s.bus         = pll_clk_pkg::BUS_ACCESS;
          next_s.rsp.pready  = 1'b1;
          next_s.rsp.pslverr = (regHit == 3'h0);
          next_s.rsp.prdata  = apbReq.pwrite ? 32'h0000_0000 : rdData;
        end
      end
      pll_clk_pkg::BUS_ACCESS: begin
        next_s.bus         = pll_clk_pkg::BUS_IDLE;
        next_s.rsp         = '0;
        if (accessDone && apbReq.pwrite) begin
          if (regHit[0]) begin
            next_s.ctrl = pll_clk_pkg::pll_ctrl_t'(apbReq.pwdata[7:0]);
          end
          if (regHit[1]) begin
            next_s.pllOutputFactor = apbReq.pwdata[7:0];
          end
        end
      end
      default: begin
        next_s.bus = pll_clk_pkg::BUS_IDLE;
        next_s.rsp = '0;
      end
    endcase

    // pin level seen from outside: three stages, accepted once two agree
    next_s.pinSync = {s.pinSync[1:0], auxClockPinIn};
    if (s.pinSync[1] == s.pinSync[2]) begin
      next_s.pinLevel = s.pinSync[2];
    end

    // output enable: code 0h hands the pin back to general I/O
    next_s.pinOe = s.ctrl.auxClockPinEnable
                   && (s.ctrl.auxClockSourceSelect != pll_clk_pkg::SEL_GPIO);

    case (s.ctrl.auxClockSourceSelect)
      pll_clk_pkg::SEL_GPIO: begin
        next_s.pinOut = 1'b0;
      end
      pll_clk_pkg::SEL_PLL: begin
        next_s.pinOut = pllLevel;
      end
      pll_clk_pkg::SEL_LOW: begin
        next_s.pinOut = 1'b0;
      end
      pll_clk_pkg::SEL_HIGH: begin
        next_s.pinOut = 1'b1;
      end
      pll_clk_pkg::SEL_XTAL: begin
        // a flop-driven pin can at best toggle every crystal cycle
        next_s.pinOut = ~s.pinOut;
      end
      pll_clk_pkg::SEL_XTAL2: begin
        next_s.pinOut = s.pinOut ^ toggleEn[0];
      end
      pll_clk_pkg::SEL_XTAL4: begin
        next_s.pinOut = s.pinOut ^ toggleEn[1];
      end
      pll_clk_pkg::SEL_XTAL8: begin
        next_s.pinOut = s.pinOut ^ toggleEn[2];
      end
      default: begin
        if (s.ctrl.auxClockSourceSelect[3:2] == pll_clk_pkg::SEL_TMR_GROUP) begin
          next_s.pinOut = s.pinOut ^ timerOverflow[s.ctrl.auxClockSourceSelect[1:0]];
        end else begin
          // reserved codes behave like constant low
          next_s.pinOut = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign apbRsp         = s.rsp;
  assign auxClockPinOut = s.pinOut;
  assign auxClockPinOe  = s.pinOe;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (!rst_n);

  sequence xtalHeld;
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_XTAL) ##1
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_XTAL);
  endsequence

  sequence divWrite;
    accessDone && apbReq.pwrite && regHit[1];
  endsequence

  sequence divRead;
    (s.bus == pll_clk_pkg::BUS_IDLE) && apbReq.psel && !apbReq.penable
    && !apbReq.pwrite && regHit[1];
  endsequence

  sequence ctrlWrite;
    accessDone && apbReq.pwrite && regHit[0];
  endsequence

  sequence unmappedSetup;
    (s.bus == pll_clk_pkg::BUS_IDLE) && apbReq.psel && !apbReq.penable
    && (regHit == 3'h0);
  endsequence

  a_gpio_release: assert property (
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_GPIO) |=> !auxClockPinOe)
    else $error("pin driven while released for general I/O");

  a_pll_follow: assert property (
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_PLL)
    |=> (auxClockPinOut == $past(pllLevel)))
    else $error("pin does not follow the PLL output");

  a_const_low: assert property (
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_LOW) |=> !auxClockPinOut)
    else $error("pin not held low");

  a_const_high: assert property (
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_HIGH) |=> auxClockPinOut)
    else $error("pin not held high");

  a_xtal_toggle: assert property (
    xtalHeld |-> (auxClockPinOut != $past(auxClockPinOut)))
    else $error("undivided crystal output missed a toggle");

  a_half_rate: assert property (
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_XTAL2)
    |=> ((auxClockPinOut != $past(auxClockPinOut)) == $past(toggleEn[0])))
    else $error("divide-by-two output toggled at the wrong cycle");

  a_timer_toggle: assert property (
    (s.ctrl.auxClockSourceSelect[3:2] == pll_clk_pkg::SEL_TMR_GROUP)
    |=> ((auxClockPinOut != $past(auxClockPinOut))
         == $past(timerOverflow[s.ctrl.auxClockSourceSelect[1:0]])))
    else $error("pin toggle does not match the timer overflow");

  // the enable must be clear two cycles running: the pin lags the control by one
  a_drive_enable: assert property (
    (!s.ctrl.auxClockPinEnable) [*2] |-> !auxClockPinOe ##1 !auxClockPinOe)
    else $error("pin driven with the enable bit clear");

  a_drive_on: assert property (
    (s.ctrl.auxClockPinEnable && (s.ctrl.auxClockSourceSelect != pll_clk_pkg::SEL_GPIO))
    |=> auxClockPinOe)
    else $error("pin not driven with the enable bit set");

  a_pll_stop: assert property (
    s.ctrl.pllPowerDown |=> !pllLevel)
    else $error("PLL output running while powered down");

  a_div_write: assert property (
    divWrite |=> (s.pllOutputFactor == $past(apbReq.pwdata[7:0])))
    else $error("output factor write not stored");

  a_div_read: assert property (
    divRead |=> apbRsp.pready && (apbRsp.prdata == {24'h000000, s.pllOutputFactor}))
    else $error("output factor read returns wrong data");

  a_quarter_rate: assert property (
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_XTAL4)
    |=> ((auxClockPinOut != $past(auxClockPinOut)) == $past(toggleEn[1])))
    else $error("divide-by-four output toggled at the wrong cycle");

  a_eighth_rate: assert property (
    (s.ctrl.auxClockSourceSelect == pll_clk_pkg::SEL_XTAL8)
    |=> ((auxClockPinOut != $past(auxClockPinOut)) == $past(toggleEn[2])))
    else $error("divide-by-eight output toggled at the wrong cycle");

  a_reserved_low: assert property (
    (&s.ctrl.auxClockSourceSelect[3:2]) |=> !auxClockPinOut)
    else $error("reserved select code does not hold the pin low");

  a_ctrl_write: assert property (
    ctrlWrite |=> (s.ctrl == $past(apbReq.pwdata[7:0])))
    else $error("control write not stored");

  // a stretched ready would complete a second access the master never asked for
  a_ready_pulse: assert property (
    apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held longer than one cycle");

  a_unmapped_err: assert property (
    unmappedSetup |=> apbRsp.pready && apbRsp.pslverr && (apbRsp.prdata == 32'h0000_0000))
    else $error("unmapped access not answered with an error");

endmodule

/* dv/aux_clock_load.sv */
`timescale 1ns/10ps
module aux_clock_load (
  input  wire logic clk_sys,
  input  wire logic auxClockPinOut,
  input  wire logic auxClockPinOe,
  input  wire logic driveEn,
  input  wire logic driveLevel,
  output logic      pinWire
);
  logic floatLevel = 1'b0;

  // no pull on the pin: an undriven wire moves every cycle so a stale level cannot pass
  always @(posedge clk_sys) begin
    floatLevel <= ~floatLevel;
  end

  always_comb begin
    if (auxClockPinOe) begin
      pinWire = auxClockPinOut;
    end else if (driveEn) begin
      pinWire = driveLevel;
    end else begin
      pinWire = floatLevel;
    end
  end
endmodule

/* dv/pll_and_clock_output_control_test.sv */
`timescale 1ns/10ps
module pll_and_clock_output_control_test;
  logic                  clk_sys       = 1'b0;
  logic                  rst_n         = 1'b0;
  pll_clk_pkg::apb_req_t apbReq        = '0;
  pll_clk_pkg::apb_rsp_t apbRsp;
  logic [3:0]            timerOverflow = 4'h0;
  logic                  pinOut;
  logic                  pinOe;
  logic                  pinWire;
  logic                  drvEn         = 1'b0;
  logic                  drvLevel      = 1'b0;
  logic                  prev;
  logic [31:0]           rd;
  logic                  err;
  int                    fails         = 0;
  int                    totalChecks   = 0;
  int                    t;
  localparam logic [11:0] CTRL_ADDR = {pll_clk_pkg::CTRL_INDEX, 2'b00};
  localparam logic [11:0] DIV_ADDR  = {pll_clk_pkg::DIV_INDEX, 2'b00};
  localparam logic [11:0] STAT_ADDR = {pll_clk_pkg::STATUS_INDEX, 2'b00};

  always #50 clk_sys = ~clk_sys;

  pll_and_clock_output_control DUT (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .apbReq        (apbReq),
    .apbRsp        (apbRsp),
    .timerOverflow (timerOverflow),
    .auxClockPinIn (pinWire),
    .auxClockPinOut(pinOut),
    .auxClockPinOe (pinOe)
  );

  aux_clock_load LOAD (
    .clk_sys       (clk_sys),
    .auxClockPinOut(pinOut),
    .auxClockPinOe (pinOe),
    .driveEn       (drvEn),
    .driveLevel    (drvLevel),
    .pinWire       (pinWire)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fails == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // accumulator phase is free running, so a count may be one off
  task automatic check_near(input string what, input int exp, input int got);
    totalChecks++;
    if (got < exp - 1 || got > exp + 1) begin
      fails++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int   n;
    logic ready;
    n = 0;
    ready = 1'b0;
    @(posedge clk_sys);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= addr;
    apbReq.pwdata <= wd;
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    // the answer is read while it stands, before the edge that completes the access
    do begin
      @(negedge clk_sys);
      n++;
      ready = (apbRsp.pready === 1'b1);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      @(posedge clk_sys);
    end while (!ready && n < 20);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (!ready) begin
      fails++;
      final_report();
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic set_ctrl(input logic [3:0] code, input logic en, input logic pd,
                          input logic [1:0] fb);
    apb(1'b1, CTRL_ADDR, {24'h0, code, en, pd, fb});
    wait_cyc(3);
  endtask

  task automatic count(input int n);
    logic last;
    t = 0;
    last = pinOut;
    repeat (n) begin
      wait_cyc(1);
      if (pinOut !== last) t++;
      last = pinOut;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("ctrl reset", {24'h0, pll_clk_pkg::CTRL_RESET}, rd);
    apb(1'b0, DIV_ADDR, 32'h0);
    check("div reset", {24'h0, pll_clk_pkg::DIV_RESET}, rd);
    apb(1'b1, DIV_ADDR, 32'h1234_56FF);
    apb(1'b0, DIV_ADDR, 32'h0);
    check("div readback", 32'h0000_00FF, rd);
    apb(1'b0, 12'hFFC, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    apb(1'b0, DIV_ADDR, 32'h0);
    check("mapped no error", 32'h0, {31'h0, err});
    set_ctrl(4'h3, 1'b1, 1'b1, 2'b10);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("ctrl readback", 32'h0000_003E, rd);
    check("pin high", 32'h1, {31'h0, pinOut});
    check("pin driven", 32'h1, {31'h0, pinOe});
    set_ctrl(4'h2, 1'b1, 1'b0, 2'b00);
    check("pin low", 32'h0, {31'h0, pinOut});
    set_ctrl(4'h3, 1'b0, 1'b0, 2'b00);
    check("pin off", 32'h0, {31'h0, pinOe});
    set_ctrl(4'hC, 1'b1, 1'b0, 2'b00);
    check("reserved low", 32'h0, {31'h0, pinOut});
    drvEn <= 1'b1;
    drvLevel <= 1'b1;
    set_ctrl(4'h0, 1'b1, 1'b0, 2'b00);
    wait_cyc(6);
    check("pin released", 32'h0, {31'h0, pinOe});
    apb(1'b0, STAT_ADDR, 32'h0);
    check("pin input high", 32'h1, rd & 32'h5);
    drvLevel <= 1'b0;
    wait_cyc(6);
    apb(1'b0, STAT_ADDR, 32'h0);
    check("pin input low", 32'h0, rd & 32'h5);
    drvEn <= 1'b0;
    for (int c = 4; c < 8; c++) begin
      set_ctrl(4'(c), 1'b1, 1'b0, 2'b00);
      count(64);
      check("crystal toggles", 32'(64 >> (c - 4)), 32'(t));
    end
    for (int i = 0; i < 4; i++) begin
      set_ctrl(4'(8 + i), 1'b1, 1'b0, 2'b00);
      prev = pinOut;
      for (int j = 0; j < 4; j++) begin
        @(posedge clk_sys);
        timerOverflow <= 4'(1 << j);
        @(posedge clk_sys);
        timerOverflow <= 4'h0;
        wait_cyc(2);
        if (i == j) prev = ~prev;
        check("timer toggle", {31'h0, prev}, {31'h0, pinOut});
      end
    end
    apb(1'b1, DIV_ADDR, 32'h0000_00FF);
    for (int f = 0; f < 4; f++) begin
      set_ctrl(4'h1, 1'b1, 1'b0, 2'(f));
      count(1020);
      check_near("pll toggles", 4 * (f == 1 ? 27 : (f == 2 ? 28 : 23)), t);
    end
    apb(1'b1, DIV_ADDR, 32'h0000_0064);
    set_ctrl(4'h1, 1'b1, 1'b0, 2'b00);
    count(1000);
    check_near("pll divided", 230, t);
    set_ctrl(4'h1, 1'b1, 1'b1, 2'b00);
    count(100);
    check("pll stopped", 32'h0, 32'(t));
    check("pll pin low", 32'h0, {31'h0, pinOut});
    apb(1'b0, STAT_ADDR, 32'h0);
    check("pll level", 32'h0, rd & 32'h2);
    final_report();
  end
endmodule
